// ===== rtl/ppi_pkg.sv
// Shared constants and types of the positioning program interpreter
package ppi_pkg;
    // Register byte offsets
    localparam logic [7:0]  PPI_OFF_CTRL = 8'h00;
    localparam logic [7:0]  PPI_OFF_CMD  = 8'h04;
    localparam logic [7:0]  PPI_OFF_FEED = 8'h08;
    localparam logic [7:0]  PPI_OFF_STMT = 8'h0C;
    localparam logic [7:0]  PPI_OFF_STAT = 8'h10;
    localparam logic [7:0]  PPI_OFF_AUX  = 8'h14;
    localparam logic [7:0]  PPI_OFF_ATTR = 8'h18;

    // Command register bit positions (write-only pulses)
    localparam int PPI_CMD_ENTER     = 0;
    localparam int PPI_CMD_MD_XFER   = 1;
    localparam int PPI_CMD_MD_OK     = 2;
    localparam int PPI_CMD_REF_SET   = 3;
    localparam int PPI_CMD_TEACH_EN  = 4;
    localparam int PPI_CMD_TEACH_DIS = 5;

    // Sticky status bit positions, write one to clear
    localparam int PPI_STAT_SYNTAX  = 2;
    localparam int PPI_STAT_REFUSED = 3;

    // Value limits of the statement fields
    localparam logic [7:0]  PPI_AUX_DEFAULT = 8'hFF;
    localparam logic [6:0]  PPI_AUX_MAX     = 7'h63;
    localparam logic [16:0] PPI_FEED_MAX    = 17'h0_FDE8;
    localparam logic [16:0] PPI_SPEED_MIN   = 17'h0_000A;
    localparam logic [16:0] PPI_DWELL_MIN   = 17'h0_0001;

    // Dwell time base
    localparam int PPI_CLK_HZ        = 50_000_000;
    localparam int PPI_DWELL_UNIT_MS = 100;
    localparam int PPI_DWELL_CYC     = PPI_CLK_HZ / 1000 * PPI_DWELL_UNIT_MS;

    typedef struct packed {
        logic       halt;
        logic       prog_end;
        logic       extra_aux;
        logic       absolute;
        logic       offset;
        logic       blend;
        logic       call;
        logic       home;
        logic       loop_end;
        logic       rep;
        logic       dwell;
        logic       rapid;
        logic       target;
        logic       has_feed;
        logic       has_aux;
        logic [6:0] aux;
    } ppi_stmt_t;

    typedef struct packed {
        logic closed_loop;
        logic unit_inch;
        logic single;
    } ppi_ctrl_t;

    typedef struct packed {
        logic loop_back;
        logic halt_pend;
        logic refused;
        logic syntax_err;
        logic wait_enter;
        logic busy;
    } ppi_stat_t;

    typedef struct packed {
        logic running;
        logic md_missing;
        logic ref_missing;
        logic teach;
        logic closed_loop;
        logic pos_reached;
        logic unit;
    } ppi_attr_t;

    typedef enum {PPI_IDLE, PPI_WAIT, PPI_MOVE, PPI_DWELL} ppi_state_t;

    localparam ppi_ctrl_t PPI_CTRL_RST = 3'h0;
    localparam ppi_attr_t PPI_ATTR_RST = 7'h30;
    localparam ppi_stmt_t PPI_STMT_RST = 22'h00_0000;
endpackage

// ===== rtl/ppi_interp.sv
// Statement interpreter of the positioning module with APB registers
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ppi_interp
    import ppi_pkg::*;
#(
    parameter int DWELL_CYC = PPI_DWELL_CYC
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        motion_done,
    input  wire logic        ref_approached,
    output logic             motion_start,
    output logic             motion_home,
    output logic             motion_abs,
    output logic             motion_blend,
    output logic             dwell_active,
    output logic      [7:0]  aux_code,
    output ppi_attr_t        axis_attr
);
    localparam int TW = (DWELL_CYC > 1) ? $clog2(DWELL_CYC) : 1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    function automatic logic ppi_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Statement ordering and value checks
    function automatic logic ppi_syntax_ok(input ppi_stmt_t s, input logic [16:0] f);
        logic ok;
        ok = 1'b1;
        if (s.call && |{s[21:16], s[14:7]})
            ok = 1'b0;
        if (s.rapid && !s.target)
            ok = 1'b0;
        if (s.dwell && (s.target || !s.has_feed))
            ok = 1'b0;
        if (s.loop_end && |{s[21:14], s[12:7]})
            ok = 1'b0;
        if (s.rep && (!s.has_feed || s.has_aux))
            ok = 1'b0;
        if (s.home && s.target)
            ok = 1'b0;
        if (s.target && !s.rapid && !s.has_feed)
            ok = 1'b0;
        if (s.has_feed && !(s.target || s.dwell || s.rep))
            ok = 1'b0;
        if (s.prog_end && s.extra_aux)
            ok = 1'b0;
        if (s.has_aux && s.aux > PPI_AUX_MAX)
            ok = 1'b0;
        if (s.has_feed && f > PPI_FEED_MAX)
            ok = 1'b0;
        if (s.target && s.has_feed && f < PPI_SPEED_MIN)
            ok = 1'b0;
        if (s.dwell && f < PPI_DWELL_MIN)
            ok = 1'b0;
        return ok;
    endfunction

    ppi_ctrl_t   ctrl;
    ppi_stmt_t   cur;
    ppi_state_t  state;
    logic [16:0] feed;
    logic [16:0] cur_feed;
    logic [16:0] dwell_left;
    logic [16:0] loop_left;
    logic [TW-1:0] tick;
    logic        loop_inf;
    logic        loop_back;
    logic        halt_pend;
    logic        syntax_err;
    logic        refused;
    logic        md_ok;

    // Bus decode
    wire logic setup    = psel & ~penable;
    wire logic access   = psel & penable & pready;
    wire logic wr       = access & pwrite;
    wire logic wr_ctrl  = wr & ppi_hit(paddr, PPI_OFF_CTRL);
    wire logic wr_cmd   = wr & ppi_hit(paddr, PPI_OFF_CMD);
    wire logic wr_feed  = wr & ppi_hit(paddr, PPI_OFF_FEED);
    wire logic wr_stmt  = wr & ppi_hit(paddr, PPI_OFF_STMT);
    wire logic wr_stat  = wr & ppi_hit(paddr, PPI_OFF_STAT);
    wire logic mapped   = ppi_hit(paddr, PPI_OFF_CTRL) | ppi_hit(paddr, PPI_OFF_CMD)
                        | ppi_hit(paddr, PPI_OFF_FEED) | ppi_hit(paddr, PPI_OFF_STMT)
                        | ppi_hit(paddr, PPI_OFF_STAT) | ppi_hit(paddr, PPI_OFF_AUX)
                        | ppi_hit(paddr, PPI_OFF_ATTR);
    // A statement cannot be replaced while the previous one still runs
    wire logic busy_err = pwrite & ppi_hit(paddr, PPI_OFF_STMT) & (state != PPI_IDLE);

    wire logic enter     = wr_cmd & pwdata[PPI_CMD_ENTER];
    wire logic md_xfer   = wr_cmd & pwdata[PPI_CMD_MD_XFER];
    wire logic ref_set   = wr_cmd & pwdata[PPI_CMD_REF_SET];
    wire logic teach_en  = wr_cmd & pwdata[PPI_CMD_TEACH_EN];
    wire logic teach_dis = wr_cmd & pwdata[PPI_CMD_TEACH_DIS];

    wire ppi_stmt_t s   = ppi_stmt_t'(pwdata[21:0]);
    wire logic syn_ok   = ppi_syntax_ok(s, feed);
    wire logic acc      = wr_stmt & ~pslverr;
    wire logic acc_ok   = acc & syn_ok;
    wire logic job      = s.target | s.home | s.dwell;
    wire logic zero_job = s.halt & ~job;
    wire logic md_bad   = (s.target | s.home) & (axis_attr.md_missing | ~md_ok);
    wire logic no_ref   = s.target & s.absolute & axis_attr.ref_missing;
    wire logic refuse   = md_bad | no_ref;
    wire logic need_ent = (job | zero_job) & (halt_pend | ctrl.single);
    wire logic go_new   = acc_ok & ~refuse & (job | zero_job) & ~need_ent;
    wire logic go_wait  = (state == PPI_WAIT) & enter;
    wire logic start_go = go_new | go_wait;
    wire ppi_stmt_t st  = go_wait ? cur : s;
    wire logic st_job   = st.target | st.home | st.dwell;
    wire logic tick_end = tick == TW'(DWELL_CYC - 1);
    wire logic dwell_end = (state == PPI_DWELL) & tick_end & (dwell_left == 17'h0_0001);
    wire logic job_end  = ((state == PPI_MOVE) & motion_done) | dwell_end;
    wire logic end_stmt = acc_ok & s.prog_end & ~job & ~zero_job;

    wire ppi_stat_t stat = '{loop_back, halt_pend, refused, syntax_err,
                            state == PPI_WAIT, state != PPI_IDLE};
    wire logic [31:0] rd_val =
        ppi_hit(paddr, PPI_OFF_CTRL) ? {29'h0, ctrl} :
        ppi_hit(paddr, PPI_OFF_FEED) ? {15'h0, feed} :
        ppi_hit(paddr, PPI_OFF_STMT) ? {10'h0, cur} :
        ppi_hit(paddr, PPI_OFF_STAT) ? {26'h0, stat} :
        ppi_hit(paddr, PPI_OFF_AUX)  ? {24'h0, aux_code} :
        ppi_hit(paddr, PPI_OFF_ATTR) ? {25'h0, axis_attr} : 32'h0000_0000;

    // Zero-wait slave: answer prepared in the setup cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & (~mapped | busy_err);
            prdata  <= (setup & ~pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl <= PPI_CTRL_RST;
            feed <= 17'h0_0000;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= ppi_ctrl_t'(pwdata[2:0]);
            if (wr_feed)
                feed <= pwdata[16:0];
        end
    end

    // Sticky errors; a new event wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            syntax_err <= 1'b0;
            refused    <= 1'b0;
        end
        else
        begin
            syntax_err <= (acc & ~syn_ok)
                        | (syntax_err & ~(wr_stat & pwdata[PPI_STAT_SYNTAX]));
            refused    <= (acc_ok & refuse)
                        | (refused & ~(wr_stat & pwdata[PPI_STAT_REFUSED]));
        end
    end

    // Statement sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state        <= PPI_IDLE;
            cur          <= PPI_STMT_RST;
            cur_feed     <= 17'h0_0000;
            halt_pend    <= 1'b0;
            motion_start <= 1'b0;
            motion_home  <= 1'b0;
            motion_abs   <= 1'b0;
            motion_blend <= 1'b0;
        end
        else
        begin
            motion_start <= 1'b0;
            if (acc_ok && !refuse && (job || zero_job) && need_ent)
            begin
                state    <= PPI_WAIT;
                cur      <= s;
                cur_feed <= feed;
            end
            if (end_stmt)
                halt_pend <= 1'b0;
            if (start_go)
            begin
                cur       <= st;
                halt_pend <= 1'b0;
                if (go_new)
                    cur_feed <= feed;
                if (st.target || st.home)
                begin
                    state        <= PPI_MOVE;
                    motion_start <= 1'b1;
                    motion_home  <= st.home;
                    motion_abs   <= st.absolute;
                    motion_blend <= st.blend & ~st.halt;
                end
                else if (st.dwell)
                    state <= PPI_DWELL;
                else
                begin
                    state     <= PPI_IDLE;
                    halt_pend <= ~ctrl.single;
                end
            end
            else if (job_end)
            begin
                state <= PPI_IDLE;
                halt_pend <= cur.halt & ~ctrl.single;
            end
        end
    end

    // Dwell timer in units of the dwell base
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tick         <= '0;
            dwell_left   <= 17'h0_0000;
            dwell_active <= 1'b0;
        end
        else if (start_go && st.dwell)
        begin
            tick         <= '0;
            dwell_left   <= go_wait ? cur_feed : feed;
            dwell_active <= 1'b1;
        end
        else if (state == PPI_DWELL)
        begin
            tick <= tick_end ? '0 : tick + 1'b1;
            if (tick_end)
                dwell_left <= dwell_left - 17'h0_0001;
            if (dwell_end)
                dwell_active <= 1'b0;
        end
    end

    // Auxiliary code output
    always_ff @(posedge clk)
    begin
        if (rst)
            aux_code <= PPI_AUX_DEFAULT;
        else if (start_go && st_job && st.has_aux)
            aux_code <= {1'b0, st.aux};
        else if (end_stmt)
            aux_code <= PPI_AUX_DEFAULT;
    end

    // Loop repetition bookkeeping
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            loop_left <= 17'h0_0000;
            loop_inf  <= 1'b0;
            loop_back <= 1'b0;
        end
        else if (acc_ok && s.rep)
        begin
            loop_left <= feed;
            loop_inf  <= feed == 17'h0_0000;
            loop_back <= 1'b0;
        end
        else if (acc_ok && s.loop_end)
        begin
            loop_back <= loop_inf | (loop_left > 17'h0_0001);
            if (!loop_inf && loop_left != 17'h0_0000)
                loop_left <= loop_left - 17'h0_0001;
        end
    end

    // Axis attributes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            axis_attr <= PPI_ATTR_RST;
            md_ok     <= 1'b0;
        end
        else
        begin
            axis_attr.unit        <= ctrl.unit_inch;
            axis_attr.closed_loop <= ctrl.closed_loop;
            if (start_go)
                axis_attr.pos_reached <= ~st_job;
            else if (job_end)
                axis_attr.pos_reached <= 1'b1;
            if (md_xfer)
            begin
                axis_attr.md_missing <= 1'b0;
                md_ok                <= pwdata[PPI_CMD_MD_OK];
            end
            if (ref_set || ref_approached)
                axis_attr.ref_missing <= 1'b0;
            if (teach_en)
                axis_attr.teach <= 1'b1;
            else if (teach_dis)
                axis_attr.teach <= 1'b0;
            if (end_stmt)
                axis_attr.running <= 1'b0;
            else if (acc_ok)
                axis_attr.running <= 1'b1;
        end
    end

    aux_change_a: assert property ($changed(aux_code) |-> motion_start || dwell_active
        || $past(end_stmt) || $past(start_go)) else $error("aux code changed without a start");
    aux_range_a: assert property (aux_code <= 8'h63 || aux_code == 8'hFF)
        else $error("aux code out of range");
    bad_stmt_a: assert property (acc && !syn_ok |=> syntax_err && state == PPI_IDLE)
        else $error("bad statement was loaded");
    halt_blend_a: assert property (motion_start && cur.halt |-> !motion_blend)
        else $error("blending kept under halt");
    single_enter_a: assert property ((state == PPI_WAIT) && !enter |=> state == PPI_WAIT)
        else $error("job left wait without enter");
    abs_refuse_a: assert property (acc_ok && no_ref |=> refused && !motion_start)
        else $error("absolute move without reference");
    md_clear_a: assert property ($fell(axis_attr.md_missing) |-> $past(md_xfer))
        else $error("data flag cleared without transfer");
    teach_on_a: assert property (teach_en |=> axis_attr.teach)
        else $error("teach-in not set");
    end_halt_a: assert property (end_stmt |=> !halt_pend)
        else $error("halt survives program end");
    dwell_done_a: assert property (dwell_end |=> state == PPI_IDLE && !dwell_active)
        else $error("dwell did not finish");
    zero_job_a: assert property (go_new && zero_job && !ctrl.single |=> halt_pend)
        else $error("lone halt did not arm");

    zero_job_c: cover property (go_wait && !cur.target && !cur.home && !cur.dwell);
    dwell_run_c: cover property (dwell_end);
    move_done_c: cover property (state == PPI_MOVE ##1 state == PPI_IDLE);
    prog_end_c: cover property (end_stmt);
endmodule

// ===== testbench/ppi_axis_model.sv
// Axis control stand-in that answers the interpreter's motion requests
`timescale 1ns/1ps
module ppi_axis_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       motion_start,
    input  wire logic       motion_home,
    input  wire logic [7:0] delay,
    output logic            motion_done,
    output logic            ref_approached
);
    logic       moving;
    logic [7:0] cnt;

    always_ff @(posedge clk)
    begin
        motion_done    <= 1'b0;
        ref_approached <= 1'b0;
        if (rst)
            moving <= 1'b0;
        else if (motion_start)
        begin
            moving <= 1'b1;
            cnt    <= delay;
        end
        else if (moving && cnt == 8'h00)
        begin
            moving         <= 1'b0;
            motion_done    <= 1'b1;
            ref_approached <= motion_home;
        end
        else if (moving)
            cnt <= cnt - 8'h01;
    end
endmodule

// ===== testbench/ppi_interp_tb.sv
// Self-checking bench of the program interpreter
`timescale 1ns/1ps
module ppi_interp_tb;
    import ppi_pkg::*;
    localparam logic [31:0] s_aux  = 32'h0000_0080;
    localparam logic [31:0] s_feed = 32'h0000_0100;
    localparam logic [31:0] s_tgt  = 32'h0000_0200;
    localparam logic [31:0] s_rpd  = 32'h0000_0400;
    localparam logic [31:0] s_dwl  = 32'h0000_0800;
    localparam logic [31:0] s_rep  = 32'h0000_1000;
    localparam logic [31:0] s_lend = 32'h0000_2000;
    localparam logic [31:0] s_home = 32'h0000_4000;
    localparam logic [31:0] s_call = 32'h0000_8000;
    localparam logic [31:0] s_blnd = 32'h0001_0000;
    localparam logic [31:0] s_ofs  = 32'h0002_0000;
    localparam logic [31:0] s_abs  = 32'h0004_0000;
    localparam logic [31:0] s_xaux = 32'h0008_0000;
    localparam logic [31:0] s_end  = 32'h0010_0000;
    localparam logic [31:0] s_halt = 32'h0020_0000;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, aux_code, delay;
    logic [31:0] pwdata, prdata, rdv;
    logic        motion_done, ref_approached, motion_start, motion_home;
    logic        motion_abs, motion_blend, dwell_active, errv;
    ppi_attr_t   axis_attr;
    int          fail_count, compares, starts;

    ppi_interp #(.DWELL_CYC(4)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .motion_done(motion_done), .ref_approached(ref_approached),
        .motion_start(motion_start), .motion_home(motion_home), .motion_abs(motion_abs),
        .motion_blend(motion_blend), .dwell_active(dwell_active), .aux_code(aux_code),
        .axis_attr(axis_attr));
    ppi_axis_model i_axis (.clk(clk), .rst(rst), .motion_start(motion_start),
        .motion_home(motion_home), .delay(delay), .motion_done(motion_done),
        .ref_approached(ref_approached));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
        if (motion_start === 1'b1)
            starts <= starts + 1;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No local limit: only the watchdog may end a wait for the answer
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic st(input logic [31:0] f, input logic [31:0] w);
        apb(1'b1, PPI_OFF_FEED, f);
        apb(1'b1, PPI_OFF_STMT, w);
    endtask

    task automatic sb(input string nm, input int b, input logic e);
        apb(1'b0, PPI_OFF_STAT, 32'h0000_0000);
        chk(nm, {31'h0, rdv[b]}, {31'h0, e});
    endtask

    task automatic go(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (20)
        begin
            @(posedge clk);
            if (motion_start === 1'b1)
                break;
        end
        seen = (motion_start === 1'b1);
        chk("motion start", {31'h0, seen}, {31'h0, e});
    endtask

    task automatic idle();
        forever
        begin
            apb(1'b0, PPI_OFF_STAT, 32'h0000_0000);
            if (rdv[0] === 1'b0)
                break;
        end
    endtask

    task automatic t_reset();
        chk("aux default", {24'h0, aux_code}, 32'h0000_00FF);
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("attr reset", rdv, 32'h0000_0030);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped error", {31'h0, errv}, 32'h0000_0001);
        apb(1'b1, PPI_OFF_CTRL, 32'h0000_0006);
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("attr unit loop", rdv, 32'h0000_0035);
        apb(1'b1, PPI_OFF_CTRL, 32'h0000_0004);
    endtask

    task automatic t_refuse();
        st(32'd100, s_tgt | s_feed);
        sb("no md refused", PPI_STAT_REFUSED, 1'b1);
        apb(1'b1, PPI_OFF_STAT, 32'h0000_000C);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0002);
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("md missing", {31'h0, rdv[5]}, 32'h0000_0000);
        st(32'd100, s_tgt | s_feed);
        sb("bad md refused", PPI_STAT_REFUSED, 1'b1);
        apb(1'b1, PPI_OFF_STAT, 32'h0000_000C);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0006);
        st(32'd100, s_tgt | s_feed | s_abs);
        sb("abs refused", PPI_STAT_REFUSED, 1'b1);
        chk("no start", starts, 0);
        apb(1'b1, PPI_OFF_STAT, 32'h0000_000C);
        st(32'd0, s_home);
        go(1'b1);
        chk("home level", {31'h0, motion_home}, 32'h0000_0001);
        idle();
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("ref missing", {31'h0, rdv[4]}, 32'h0000_0000);
        st(32'd100, s_tgt | s_feed | s_abs);
        go(1'b1);
        chk("abs level", {31'h0, motion_abs}, 32'h0000_0001);
        idle();
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0010);
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("teach on", {31'h0, rdv[3]}, 32'h0000_0001);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0020);
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("teach off", {31'h0, rdv[3]}, 32'h0000_0000);
    endtask

    task automatic t_table();
        logic [31:0] w [17] = '{s_tgt|s_feed, s_tgt|s_feed, s_tgt|s_feed, s_dwl|s_feed,
            s_dwl|s_feed, s_rep|s_feed, s_rep|s_feed, s_rep|s_feed, s_call|s_tgt|s_feed,
            s_rpd|s_feed, s_dwl|s_tgt|s_feed, s_lend|s_aux, s_rep|s_feed|s_aux,
            s_home|s_tgt|s_feed, s_tgt, s_ofs|s_feed, s_end|s_tgt|s_feed|s_aux|s_xaux};
        logic [31:0] f [17] = '{9, 10, 65001, 0, 1, 0, 65000, 65001, 100, 100, 100, 0, 3,
            100, 0, 100, 100};
        logic        e [17] = '{1, 0, 1, 1, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};
        int          n;
        for (int i = 0; i < 17; i++)
        begin
            n = starts;
            st(f[i], w[i]);
            sb("syntax flag", PPI_STAT_SYNTAX, e[i]);
            if (e[i])
                chk("not loaded", starts, n);
            apb(1'b1, PPI_OFF_STAT, 32'h0000_000C);
            idle();
        end
        st(32'd0, s_rep | s_feed);
        st(32'd0, s_lend);
        st(32'd0, s_lend);
        sb("endless loop", 5, 1'b1);
    endtask

    task automatic t_aux();
        int n;
        st(32'd0, s_ofs | s_aux | 32'd5);
        // Look after the write edge so that a wrong update would show
        @(posedge clk);
        chk("aux ignored", {24'h0, aux_code}, 32'h0000_00FF);
        st(32'd100, s_tgt | s_feed | s_aux | 32'd10);
        go(1'b1);
        chk("aux at start", {24'h0, aux_code}, 32'h0000_000A);
        idle();
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("reached", {31'h0, rdv[1]}, 32'h0000_0001);
        chk("running", {31'h0, rdv[6]}, 32'h0000_0001);
        st(32'd100, s_tgt | s_feed);
        go(1'b1);
        chk("aux held", {24'h0, aux_code}, 32'h0000_000A);
        idle();
        st(32'd3, s_dwl | s_feed | s_aux | 32'd30);
        n = 0;
        repeat (40)
        begin
            @(posedge clk);
            if (dwell_active === 1'b1)
                n++;
        end
        chk("dwell cycles", {31'h0, n >= 12 && n <= 13}, 32'h0000_0001);
        chk("aux dwell", {24'h0, aux_code}, 32'h0000_001E);
        st(32'd0, s_end);
        @(posedge clk);
        chk("aux after end", {24'h0, aux_code}, 32'h0000_00FF);
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("finished", {31'h0, rdv[6]}, 32'h0000_0000);
    endtask

    task automatic t_halt();
        st(32'd100, s_tgt | s_feed | s_halt | s_blnd);
        go(1'b1);
        chk("halt no blend", {31'h0, motion_blend}, 32'h0000_0000);
        idle();
        st(32'd0, s_ofs);
        sb("offset no wait", 1, 1'b0);
        st(32'd100, s_tgt | s_feed);
        go(1'b0);
        sb("waits enter", 1, 1'b1);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0001);
        go(1'b1);
        idle();
        st(32'd0, s_halt);
        st(32'd0, s_halt);
        sb("second zero job", 1, 1'b1);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0001);
        idle();
        st(32'd100, s_tgt | s_feed);
        sb("zero job halts", 1, 1'b1);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0001);
        go(1'b1);
        idle();
        st(32'd100, s_tgt | s_feed | s_halt);
        go(1'b1);
        idle();
        st(32'd0, s_end);
        sb("end drops halt", 4, 1'b0);
        apb(1'b1, PPI_OFF_CTRL, 32'h0000_0005);
        st(32'd100, s_tgt | s_feed | s_halt);
        go(1'b0);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0001);
        go(1'b1);
        idle();
        st(32'd100, s_tgt | s_feed);
        sb("one enter only", 1, 1'b1);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0001);
        go(1'b1);
        idle();
        st(32'd0, s_halt);
        sb("single zero job", 1, 1'b1);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0001);
        idle();
        apb(1'b1, PPI_OFF_CTRL, 32'h0000_0004);
        delay <= 8'd40;
        st(32'd100, s_tgt | s_feed);
        apb(1'b1, PPI_OFF_STMT, s_tgt | s_feed);
        chk("busy refusal", {31'h0, errv}, 32'h0000_0001);
        idle();
        st(32'd0, s_end);
    endtask

    task automatic t_ref_set();
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("attr after reset", rdv, 32'h0000_0030);
        apb(1'b1, PPI_OFF_CMD, 32'h0000_0008);
        apb(1'b0, PPI_OFF_ATTR, 32'h0000_0000);
        chk("ref set", {31'h0, rdv[4]}, 32'h0000_0000);
        chk("attr port", {25'h0, axis_attr}, 32'h0000_0020);
    endtask

    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #400_000;
        fail_count++;
        test_done();
    end

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        delay = 8'd3;
        fail_count = 0;
        compares = 0;
        starts = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_refuse();
        t_table();
        t_aux();
        t_halt();
        t_ref_set();
        test_done();
    end
endmodule
